/* core/ams_cfg.svh */
// Purpose: constants of the converter mode sequencer
// Assumes: 10 MHz system clock, AXI4-Lite byte addresses
// Notes: offsets are byte addresses of aligned 32-bit words
`ifndef AMS_CFG_SVH
`define AMS_CFG_SVH

`define AMS_MODE_OFS 8'h00
`define AMS_CFG_OFS 8'h04
`define AMS_IO_OFS 8'h08
`define AMS_COMM_OFS 8'h0C
`define AMS_STAT_OFS 8'h10
`define AMS_DATA_OFS 8'h14
`define AMS_OFSC_OFS 8'h18
`define AMS_FSC_OFS 8'h1C

`define AMS_MODE_RST 16'h000A
`define AMS_CFG_RST 16'h0710
`define AMS_IO_RST 8'h00

`define AMS_MSEL_MSB 15
`define AMS_MSEL_LSB 13
`define AMS_CLKO_MSB 7
`define AMS_CLKO_LSB 6
`define AMS_CLKO_ON 2'h1
`define AMS_BIAS_MSB 15
`define AMS_BIAS_LSB 14
`define AMS_BO_BIT 13
`define AMS_GAIN_MSB 10
`define AMS_GAIN_LSB 8
`define AMS_CH_MSB 2
`define AMS_CH_LSB 0
`define AMS_EXC_MSB 1
`define AMS_EXC_LSB 0
`define AMS_RDREQ_BIT 0
`define AMS_CONTRD_BIT 1
`define AMS_RDY_BIT 7

`define AMS_RESP_OKAY 2'h0
`define AMS_RESP_SLVERR 2'h2

`define AMS_RESULT_BITS 24
`define AMS_CLK_PERIOD_NS 100
`define AMS_OSC_SETTLE_NS 1000000
`define AMS_CONV_PERIOD_NS 10000000
`define AMS_FIRST_PERIODS 3'h2
`define AMS_SINGLE_PERIODS 3'h2
`define AMS_CAL_PERIODS 3'h2
`define AMS_CAL_FS_HI_PERIODS 3'h4

`endif

/* core/ams_pkg.sv */
// Purpose: types of the converter mode sequencer
// Assumes: mode codes follow the 3-bit mode select field
// Notes: none
package ams_pkg;

  typedef enum logic [2:0] {
    MODE_CONT = 3'h0,
    MODE_SINGLE = 3'h1,
    MODE_IDLE = 3'h2,
    MODE_PDOWN = 3'h3,
    MODE_INT_ZS = 3'h4,
    MODE_INT_FS = 3'h5,
    MODE_SYS_ZS = 3'h6,
    MODE_SYS_FS = 3'h7
  } ams_mode_t;

  typedef enum logic [2:0] {
    ST_CONV,
    ST_OSC,
    ST_SCONV,
    ST_CAL,
    ST_IDLE,
    ST_PDOWN
  } ams_state_t;

endpackage : ams_pkg

/* core/ams_sync2.sv */
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs are levels from outside the clock domain
// Notes: only the second flop is visible outside
`timescale 1ns/10ps
module ams_sync2 #(
  parameter int unsigned WIDTH = 2,
  parameter logic [WIDTH-1:0] RESET_VAL = '1
)(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      meta_q <= RESET_VAL;
      sync_q <= RESET_VAL;
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule : ams_sync2

/* core/ams_coef_mem.sv */
// Purpose: per-channel calibration coefficient store
// Assumes: one write port, one registered read port
// Notes: contents are undefined until first calibration
`timescale 1ns/10ps
module ams_coef_mem (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic we_in,
  input wire logic [2:0] waddr_in,
  input wire logic [23:0] wdata_in,
  input wire logic [2:0] raddr_in,
  output logic [23:0] rdata_out
);
  logic [23:0] mem_q [0:7];
  logic [23:0] rdata_q;

  always_ff @(posedge clk_in)
  begin
    if (we_in)
      mem_q[waddr_in] <= wdata_in;
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      rdata_q <= 24'h000000;
    else
      rdata_q <= mem_q[raddr_in];
  end

  assign rdata_out = rdata_q;
endmodule : ams_coef_mem

/* core/ams_mode_seq.sv */
// Purpose: operating-mode sequencer of a sigma-delta converter
// Assumes: conv_data_in is the filter output, same clock domain
// Notes: registers over AXI4-Lite, results shift out on a serial pin
// Function
// - 3-bit mode field decoded; code zero, continuous conversion, after reset.
// - continuous mode converts repeatedly, stores result, drives ready low.
// - with continuous read on, each result shifts out on serial clocks.
// - a read request write shifts out the stored result.
// - after restart or mode, config or io write, first result two periods later.
// - later continuous results once every output-rate period.
// - single mode waits one millisecond for oscillator before converting.
// - single conversion takes two periods, stores, ready low, then power-down.
// - single result kept and ready low until read, or a mode, config or io write.
// - idle holds filter and modulator reset, modulator clocks still run.
// - power-down turns off all circuitry, sources, bias and clock output.
// - internal zero-scale shorts the channel, done in two periods.
// - calibration drives ready high at start, low at end, then idle.
// - zero-scale calibrations store offset coefficient of selected channel.
// - internal full-scale: two periods at unity gain, four otherwise.
// - full-scale calibrations store full-scale coefficient of channel.
// - system full-scale uses host input on selected pins, two periods.
// - mode register write resets modulator and filter, sets not-ready.
// - mode field sits in the top three bits of the mode register.
`timescale 1ns/10ps
`include "ams_cfg.svh"
module ams_mode_seq
  import ams_pkg::*;
#(
  parameter int unsigned CONV_PERIOD_CYC =
    `AMS_CONV_PERIOD_NS / `AMS_CLK_PERIOD_NS,
  parameter int unsigned OSC_SETTLE_CYC =
    (`AMS_OSC_SETTLE_NS + `AMS_CLK_PERIOD_NS - 1) / `AMS_CLK_PERIOD_NS
)(
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic [7:0] awaddr_in,
  input wire logic awvalid_in,
  output logic awready_out,
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] wstrb_in,
  input wire logic wvalid_in,
  output logic wready_out,
  output logic [1:0] bresp_out,
  output logic bvalid_out,
  input wire logic bready_in,
  input wire logic [7:0] araddr_in,
  input wire logic arvalid_in,
  output logic arready_out,
  output logic [31:0] rdata_out,
  output logic [1:0] rresp_out,
  output logic rvalid_out,
  input wire logic rready_in,
  input wire logic [23:0] conv_data_in,
  input wire logic sclk_in,
  input wire logic cs_n_in,
  output logic dout_out,
  output logic ready_n_out,
  output logic mod_reset_out,
  output logic mod_clk_en_out,
  output logic input_short_out,
  output logic fs_ref_out,
  output logic exc_current_en_out,
  output logic burnout_en_out,
  output logic bias_en_out,
  output logic clock_output_driver_en_out
);
  logic aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [7:0] waddr_q, waddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [1:0] wstrb_q, wstrb_d;
  logic awready_q, awready_d, wready_q, wready_d;
  logic bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic [15:0] mode_q, mode_d, cfg_q, cfg_d;
  logic [7:0] io_q, io_d;
  logic cont_rd_q, cont_rd_d, restart_q, restart_d;
  logic rd_req, data_rd, wr_fire;
  ams_state_t state_q, state_d;
  logic [31:0] cyc_q, cyc_d;
  logic [2:0] per_left_q, per_left_d;
  logic [23:0] data_q, data_d;
  logic rdy_q, rdy_d, tick, last, result_evt, ofs_we, fs_we;
  logic hw_mode_set;
  ams_mode_t hw_mode, mode_sel;
  logic mod_rst_q, mod_rst_d, clk_en_q, clk_en_d, short_q, short_d;
  logic fsref_q, fsref_d, exc_q, exc_d, bo_q, bo_d, bias_q, bias_d;
  logic clko_q, clko_d, pwr_on;
  logic [2:0] chan, gain;
  logic [23:0] ofs_rd, fs_rd, shift_q, shift_d;
  logic [4:0] bits_q, bits_d;
  logic [1:0] pin_s;
  logic sclk_prev_q, dout_q, dout_d, ser_done, sclk_fall;

  function automatic logic [15:0] merge16(input logic [15:0] old_v,
    input logic [15:0] new_v, input logic [1:0] strb);
    merge16 = {strb[1] ? new_v[15:8] : old_v[15:8],
               strb[0] ? new_v[7:0] : old_v[7:0]};
  endfunction : merge16

  assign mode_sel = ams_mode_t'(mode_q[`AMS_MSEL_MSB:`AMS_MSEL_LSB]);
  assign chan = cfg_q[`AMS_CH_MSB:`AMS_CH_LSB];
  assign gain = cfg_q[`AMS_GAIN_MSB:`AMS_GAIN_LSB];
  assign wr_fire = aw_have_q && w_have_q && !bvalid_q;

  // register bus; writes take address and data in either order
  always_comb
  begin
    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    waddr_d = waddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    arready_d = arready_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    mode_d = mode_q;
    cfg_d = cfg_q;
    io_d = io_q;
    cont_rd_d = cont_rd_q;
    restart_d = 1'b0;
    rd_req = 1'b0;
    data_rd = 1'b0;
    if (awvalid_in && awready_q)
    begin
      aw_have_d = 1'b1;
      waddr_d = awaddr_in;
    end
    if (wvalid_in && wready_q)
    begin
      w_have_d = 1'b1;
      wdata_d = wdata_in;
      wstrb_d = wstrb_in[1:0];
    end
    if (bvalid_q && bready_in)
      bvalid_d = 1'b0;
    // hardware falls back to idle or power-down; a mode register write overrides
    if (hw_mode_set)
      mode_d[`AMS_MSEL_MSB:`AMS_MSEL_LSB] = hw_mode;
    if (wr_fire)
    begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = `AMS_RESP_OKAY;
      case ({waddr_q[7:2], 2'h0})
        `AMS_MODE_OFS:
        begin
          mode_d = merge16(mode_q, wdata_q[15:0], wstrb_q);
          restart_d = 1'b1;
        end
        `AMS_CFG_OFS:
        begin
          cfg_d = merge16(cfg_q, wdata_q[15:0], wstrb_q);
          restart_d = 1'b1;
        end
        `AMS_IO_OFS:
        begin
          if (wstrb_q[0])
            io_d = wdata_q[7:0];
          restart_d = 1'b1;
        end
        `AMS_COMM_OFS:
        begin
          if (wstrb_q[0])
          begin
            rd_req = wdata_q[`AMS_RDREQ_BIT];
            cont_rd_d = wdata_q[`AMS_CONTRD_BIT];
          end
        end
        `AMS_STAT_OFS, `AMS_DATA_OFS, `AMS_OFSC_OFS, `AMS_FSC_OFS:
          bresp_d = `AMS_RESP_OKAY;
        default:
          bresp_d = `AMS_RESP_SLVERR;
      endcase
    end
    awready_d = !aw_have_d && !bvalid_d;
    wready_d = !w_have_d && !bvalid_d;
    if (rvalid_q && rready_in)
    begin
      rvalid_d = 1'b0;
      arready_d = 1'b1;
    end
    if (arvalid_in && arready_q)
    begin
      arready_d = 1'b0;
      rvalid_d = 1'b1;
      rresp_d = `AMS_RESP_OKAY;
      rdata_d = 32'h00000000;
      case ({araddr_in[7:2], 2'h0})
        `AMS_MODE_OFS: rdata_d[15:0] = mode_q;
        `AMS_CFG_OFS: rdata_d[15:0] = cfg_q;
        `AMS_IO_OFS: rdata_d[7:0] = io_q;
        `AMS_COMM_OFS: rdata_d[`AMS_CONTRD_BIT] = cont_rd_q;
        `AMS_STAT_OFS:
        begin
          rdata_d[`AMS_RDY_BIT] = rdy_q;
          rdata_d[2:0] = chan;
        end
        `AMS_DATA_OFS:
        begin
          rdata_d[23:0] = data_q;
          data_rd = 1'b1;
        end
        `AMS_OFSC_OFS: rdata_d[23:0] = ofs_rd;
        `AMS_FSC_OFS: rdata_d[23:0] = fs_rd;
        default: rresp_d = `AMS_RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      waddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 2'h0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= `AMS_RESP_OKAY;
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rresp_q <= `AMS_RESP_OKAY;
      rdata_q <= 32'h00000000;
      mode_q <= `AMS_MODE_RST;
      cfg_q <= `AMS_CFG_RST;
      io_q <= `AMS_IO_RST;
      cont_rd_q <= 1'b0;
      restart_q <= 1'b1;
    end
    else
    begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      waddr_q <= waddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      mode_q <= mode_d;
      cfg_q <= cfg_d;
      io_q <= io_d;
      cont_rd_q <= cont_rd_d;
      restart_q <= restart_d;
    end
  end

  assign tick = (cyc_q == CONV_PERIOD_CYC - 1);
  assign last = tick && (per_left_q == 3'h1);

  // sequencer; a restart always re-enters from the mode field
  always_comb
  begin
    state_d = state_q;
    cyc_d = tick ? 32'h00000000 : cyc_q + 32'h00000001;
    per_left_d = per_left_q;
    data_d = data_q;
    rdy_d = rdy_q;
    hw_mode_set = 1'b0;
    hw_mode = MODE_IDLE;
    result_evt = 1'b0;
    ofs_we = 1'b0;
    fs_we = 1'b0;
    if (data_rd || ser_done)
      rdy_d = 1'b1;
    if (restart_q)
    begin
      cyc_d = 32'h00000000;
      rdy_d = 1'b1;
      unique case (mode_sel)
        MODE_CONT:
        begin
          state_d = ST_CONV;
          per_left_d = `AMS_FIRST_PERIODS;
        end
        MODE_SINGLE: state_d = ST_OSC;
        MODE_IDLE: state_d = ST_IDLE;
        MODE_PDOWN: state_d = ST_PDOWN;
        MODE_INT_FS:
        begin
          state_d = ST_CAL;
          per_left_d = (gain == 3'h0) ? `AMS_CAL_PERIODS
                                      : `AMS_CAL_FS_HI_PERIODS;
        end
        MODE_INT_ZS, MODE_SYS_ZS, MODE_SYS_FS:
        begin
          state_d = ST_CAL;
          per_left_d = `AMS_CAL_PERIODS;
        end
      endcase
    end
    else
    begin
      unique case (state_q)
        ST_CONV:
        begin
          if (tick)
            per_left_d = per_left_q - 3'h1;
          if (last)
          begin
            result_evt = 1'b1;
            per_left_d = 3'h1;
          end
        end
        ST_OSC:
        begin
          if (cyc_q == OSC_SETTLE_CYC - 1)
          begin
            state_d = ST_SCONV;
            cyc_d = 32'h00000000;
            per_left_d = `AMS_SINGLE_PERIODS;
          end
        end
        ST_SCONV:
        begin
          if (tick)
            per_left_d = per_left_q - 3'h1;
          if (last)
          begin
            result_evt = 1'b1;
            hw_mode_set = 1'b1;
            hw_mode = MODE_PDOWN;
            state_d = ST_PDOWN;
          end
        end
        ST_CAL:
        begin
          if (tick)
            per_left_d = per_left_q - 3'h1;
          if (last)
          begin
            rdy_d = 1'b0;
            hw_mode_set = 1'b1;
            hw_mode = MODE_IDLE;
            state_d = ST_IDLE;
            ofs_we = !mode_sel[0];
            fs_we = mode_sel[0];
          end
        end
        ST_IDLE, ST_PDOWN: cyc_d = 32'h00000000;
      endcase
    end
    // a fresh result beats a read in the same cycle
    if (result_evt)
    begin
      data_d = conv_data_in;
      rdy_d = 1'b0;
    end
  end

  assign pwr_on = (state_d != ST_PDOWN);

  always_comb
  begin
    mod_rst_d = restart_q || (state_d == ST_IDLE) ||
      (state_d == ST_PDOWN) || (state_d == ST_OSC);
    clk_en_d = pwr_on && (state_d != ST_OSC);
    short_d = (state_d == ST_CAL) && (mode_sel == MODE_INT_ZS);
    fsref_d = (state_d == ST_CAL) && (mode_sel == MODE_INT_FS);
    exc_d = pwr_on && (io_q[`AMS_EXC_MSB:`AMS_EXC_LSB] != 2'h0);
    bo_d = pwr_on && cfg_q[`AMS_BO_BIT];
    bias_d = pwr_on && (cfg_q[`AMS_BIAS_MSB:`AMS_BIAS_LSB] != 2'h0);
    clko_d = pwr_on &&
      (mode_q[`AMS_CLKO_MSB:`AMS_CLKO_LSB] == `AMS_CLKO_ON);
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      state_q <= ST_IDLE;
      cyc_q <= 32'h00000000;
      per_left_q <= 3'h0;
      data_q <= 24'h000000;
      rdy_q <= 1'b1;
      mod_rst_q <= 1'b1;
      clk_en_q <= 1'b0;
      short_q <= 1'b0;
      fsref_q <= 1'b0;
      exc_q <= 1'b0;
      bo_q <= 1'b0;
      bias_q <= 1'b0;
      clko_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cyc_q <= cyc_d;
      per_left_q <= per_left_d;
      data_q <= data_d;
      rdy_q <= rdy_d;
      mod_rst_q <= mod_rst_d;
      clk_en_q <= clk_en_d;
      short_q <= short_d;
      fsref_q <= fsref_d;
      exc_q <= exc_d;
      bo_q <= bo_d;
      bias_q <= bias_d;
      clko_q <= clko_d;
    end
  end

  ams_coef_mem u_ofs_mem (
    .clk_in(clk_sys_in),
    .reset_in(reset_in),
    .we_in(ofs_we),
    .waddr_in(chan),
    .wdata_in(conv_data_in),
    .raddr_in(chan),
    .rdata_out(ofs_rd)
  );

  ams_coef_mem u_fs_mem (
    .clk_in(clk_sys_in),
    .reset_in(reset_in),
    .we_in(fs_we),
    .waddr_in(chan),
    .wdata_in(conv_data_in),
    .raddr_in(chan),
    .rdata_out(fs_rd)
  );

  ams_sync2 #(
    .WIDTH(2),
    .RESET_VAL(2'h3)
  ) u_pin_sync (
    .clk_in(clk_sys_in),
    .reset_in(reset_in),
    .async_in({cs_n_in, sclk_in}),
    .sync_out(pin_s)
  );

  // serial output changes on the falling shift clock edge
  assign sclk_fall = sclk_prev_q && !pin_s[0];

  always_comb
  begin
    shift_d = shift_q;
    bits_d = bits_q;
    ser_done = 1'b0;
    if ((result_evt && cont_rd_q) || rd_req)
    begin
      shift_d = result_evt ? conv_data_in : data_q;
      bits_d = 5'(`AMS_RESULT_BITS);
    end
    else if (sclk_fall && !pin_s[1] && (bits_q != 5'h00))
    begin
      shift_d = {shift_q[22:0], 1'b0};
      bits_d = bits_q - 5'h01;
      ser_done = (bits_q == 5'h01);
    end
    dout_d = shift_d[23];
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      shift_q <= 24'h000000;
      bits_q <= 5'h00;
      sclk_prev_q <= 1'b1;
      dout_q <= 1'b0;
    end
    else
    begin
      shift_q <= shift_d;
      bits_q <= bits_d;
      sclk_prev_q <= pin_s[0];
      dout_q <= dout_d;
    end
  end

  assign awready_out = awready_q;
  assign wready_out = wready_q;
  assign bresp_out = bresp_q;
  assign bvalid_out = bvalid_q;
  assign arready_out = arready_q;
  assign rdata_out = rdata_q;
  assign rresp_out = rresp_q;
  assign rvalid_out = rvalid_q;
  assign dout_out = dout_q;
  assign ready_n_out = rdy_q;
  assign mod_reset_out = mod_rst_q;
  assign mod_clk_en_out = clk_en_q;
  assign input_short_out = short_q;
  assign fs_ref_out = fsref_q;
  assign exc_current_en_out = exc_q;
  assign burnout_en_out = bo_q;
  assign bias_en_out = bias_q;
  assign clock_output_driver_en_out = clko_q;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);

  a_default_mode_cont: assert property ($past(reset_in) |->
    mode_sel == MODE_CONT) else $error("mode not continuous after reset");
  a_first_two_per: assert property (restart_q && mode_sel == MODE_CONT
    |=> state_q == ST_CONV && per_left_q == 3'h2)
    else $error("first result not two periods");
  a_conv_result: assert property (state_q == ST_CONV && last
    && !restart_q |=> !rdy_q && data_q == $past(conv_data_in)
    && per_left_q == 3'h1) else $error("continuous result lost");
  a_osc_wait: assert property (restart_q && mode_sel == MODE_SINGLE
    |=> state_q == ST_OSC ##1 state_q == ST_OSC)
    else $error("single started without settle");
  a_single_pdown: assert property (state_q == ST_SCONV && last
    && !restart_q && !wr_fire |=> state_q == ST_PDOWN && !rdy_q
    && mode_sel == MODE_PDOWN) else $error("single did not power down");
  a_single_hold: assert property (state_q == ST_PDOWN && !rdy_q
    && !restart_q && !data_rd && !ser_done |=> !rdy_q)
    else $error("ready lost before read");
  a_idle_outputs: assert property (state_q == ST_IDLE && !restart_q
    |=> mod_rst_q && clk_en_q) else $error("idle outputs wrong");
  a_pdown_off: assert property (state_q == ST_PDOWN && !restart_q
    |=> !clk_en_q && !exc_q && !bo_q && !bias_q && !clko_q)
    else $error("power-down left circuits on");
  a_cal_busy: assert property (state_q == ST_CAL |-> rdy_q)
    else $error("ready low during calibration");
  a_cal_end_idle: assert property (state_q == ST_CAL && last
    && !restart_q && !wr_fire |=> state_q == ST_IDLE && !rdy_q
    && mode_sel == MODE_IDLE) else $error("calibration end wrong");
  a_cal_coef_sel: assert property (state_q == ST_CAL && last
    && !restart_q |->
    ofs_we == (mode_sel == MODE_INT_ZS || mode_sel == MODE_SYS_ZS) &&
    fs_we == (mode_sel == MODE_INT_FS || mode_sel == MODE_SYS_FS))
    else $error("coefficient stored to wrong register");
  a_int_fs_len: assert property (restart_q && mode_sel == MODE_INT_FS
    |=> per_left_q == (($past(gain) == 3'h0) ? 3'h2 : 3'h4))
    else $error("full-scale calibration length wrong");
  a_write_notready: assert property (restart_q |=> rdy_q
    && mod_rst_q) else $error("mode write did not reset");
  a_serial_load: assert property (result_evt && cont_rd_q
    |=> bits_q == 5'h18 && dout_q == $past(conv_data_in[23]))
    else $error("continuous read not loaded");
endmodule : ams_mode_seq

/* dv/ams_host_model.sv */
// Purpose: serial host model for the result link
// Assumes: 800 ns shift clock
// Notes: clock stands high outside frames
`timescale 1ns/10ps
module ams_host_model (
  input wire logic dout_in,
  output logic sclk_out,
  output logic cs_n_out
);
  initial sclk_out = 1'b1;
  initial cs_n_out = 1'b1;
  // sample before each fall, so the first bit needs no clock
  task automatic shift(output logic [23:0] w);
    cs_n_out = 1'b0;
    #400;
    for (int i = 0; i < 24; i++)
    begin
      w = {w[22:0], dout_in};
      sclk_out = 1'b0;
      #400;
      sclk_out = 1'b1;
      #400;
    end
    cs_n_out = 1'b1;
  endtask : shift
endmodule : ams_host_model

/* dv/test_ams_mode_seq.sv */
// Purpose: self-checking bench of the mode sequencer
// Assumes: short conversion period and settle counts
// Notes: register reads checked off a queue
`timescale 1ns/10ps
module test_ams_mode_seq;
  localparam int P = 400;
  localparam int OSC = 20;
  logic clk_sys_in = 1'b0;
  logic reset_in = 1'b1;
  logic [7:0] awaddr_in = 8'h00, araddr_in = 8'h00;
  logic awvalid_in = 1'b0, wvalid_in = 1'b0, bready_in = 1'b0;
  logic arvalid_in = 1'b0, rready_in = 1'b0;
  logic [31:0] wdata_in = 32'h0, rdata_out;
  logic [3:0] wstrb_in = 4'hF;
  logic [23:0] conv_data_in = 24'h0, v, w;
  logic awready_out, wready_out, bvalid_out, arready_out, rvalid_out;
  logic [1:0] bresp_out, rresp_out;
  logic sclk_in, cs_n_in, dout_out, ready_n_out, mod_reset_out;
  logic mod_clk_en_out, input_short_out, fs_ref_out, exc_current_en_out;
  logic burnout_en_out, bias_en_out, clock_output_driver_en_out;
  logic [33:0] q[$];
  logic [33:0] qb[$];
  int n_mismatch = 0;
  int n_compared = 0;
  always #50 clk_sys_in = ~clk_sys_in;
  ams_mode_seq #(.CONV_PERIOD_CYC(P), .OSC_SETTLE_CYC(OSC)) ams_mode_seq_i (
    .clk_sys_in, .reset_in, .awaddr_in, .awvalid_in, .awready_out,
    .wdata_in, .wstrb_in, .wvalid_in, .wready_out, .bresp_out, .bvalid_out,
    .bready_in, .araddr_in, .arvalid_in, .arready_out, .rdata_out,
    .rresp_out, .rvalid_out, .rready_in, .conv_data_in, .sclk_in, .cs_n_in,
    .dout_out, .ready_n_out, .mod_reset_out, .mod_clk_en_out,
    .input_short_out, .fs_ref_out, .exc_current_en_out, .burnout_en_out,
    .bias_en_out, .clock_output_driver_en_out);
  ams_host_model ams_host_model_i (.dout_in(dout_out), .sclk_out(sclk_in),
    .cs_n_out(cs_n_in));
  task automatic chk(input logic [33:0] s, input logic [33:0] e);
    n_compared++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("Error t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  // one edge first, so a strobe is never set twice in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    // nothing is mapped above the last coefficient word
    qb.push_back(34'((a[7:5] != 3'h0) ? 2'h2 : 2'h0));
    awaddr_in <= a;
    wdata_in <= d;
    awvalid_in <= 1'b1;
    wvalid_in <= 1'b1;
    bready_in <= 1'b1;
    do
    begin
      @(posedge clk_sys_in);
      if (awready_out) awvalid_in <= 1'b0;
      if (wready_out) wvalid_in <= 1'b0;
    end while (!bvalid_out);
    bready_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    @(posedge clk_sys_in);
    q.push_back(e);
    araddr_in <= a;
    arvalid_in <= 1'b1;
    rready_in <= 1'b1;
    do
    begin
      @(posedge clk_sys_in);
      if (arready_out) arvalid_in <= 1'b0;
    end while (!rvalid_out);
    rready_in <= 1'b0;
  endtask : rd
  always @(posedge clk_sys_in)
  begin
    if (rvalid_out && rready_in)
      chk({rresp_out, rdata_out}, q.pop_front());
    if (bvalid_out && bready_in)
      chk(34'(bresp_out), qb.pop_front());
  end
  // bus latency blurs the start, hence the small window
  task automatic wait_rdy(input int n);
    int c;
    c = 0;
    while (ready_n_out !== 1'b0 && c < 5000)
    begin
      @(posedge clk_sys_in);
      c++;
    end
    chk(34'(c > n - 6 && c < n + 6), 34'h1);
  endtask : wait_rdy
  task automatic print_verdict;
    $display("mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  initial
  begin
    #2000000;
    n_mismatch++;
    print_verdict;
  end
  initial
  begin
    v = 24'($urandom(95));
    conv_data_in <= v;
    repeat (20) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    wait_rdy(2 * P);
    rd(8'h00, {2'h0, 32'h000A});
    rd(8'h20, {2'h2, 32'h0});
    rd(8'h14, {10'h0, v});
    wait_rdy(P - 6);
    wr(8'h0C, 32'h2);
    repeat (P) @(posedge clk_sys_in);
    ams_host_model_i.shift(w);
    chk(w, v);
    chk(ready_n_out, 1'b1);
    wr(8'h0C, 32'h1);
    ams_host_model_i.shift(w);
    chk(w, v);
    wr(8'h08, 32'h3);
    wr(8'h04, 32'hE110);
    // enables register one edge after the config word lands
    @(posedge clk_sys_in);
    chk({exc_current_en_out, burnout_en_out, bias_en_out}, 3'h7);
    v = 24'($urandom);
    conv_data_in <= v;
    wr(8'h00, 32'h2040);
    wait_rdy(OSC + 2 * P);
    repeat (50) @(posedge clk_sys_in);
    chk(ready_n_out, 1'b0);
    chk({exc_current_en_out, burnout_en_out, bias_en_out,
      clock_output_driver_en_out}, 4'h0);
    rd(8'h00, {2'h0, 32'h6040});
    rd(8'h14, {10'h0, v});
    for (int m = 4; m < 8; m++)
    begin
      v = 24'($urandom);
      conv_data_in <= v;
      wr(8'h00, 32'(m << 13) | 32'h0040);
      repeat (2) @(posedge clk_sys_in);
      chk({ready_n_out, input_short_out, fs_ref_out},
        {1'b1, m == 4, m == 5});
      wait_rdy(m == 5 ? 4 * P : 2 * P);
      repeat (2) @(posedge clk_sys_in);
      chk({mod_reset_out, mod_clk_en_out}, 2'h3);
      rd(8'h00, {2'h0, 32'h4040});
      rd(m[0] ? 8'h1C : 8'h18, {10'h0, v});
    end
    print_verdict;
  end
endmodule : test_ams_mode_seq
